// ---- usb_root_ports.sv ----
// Purpose: Root-port status, frame scheduling gate, suspend/resume flags and bus-master packing
// Assumes: All inputs synchronous to clk_sys_i; byte enables on the master side are active low
// Notes: Register reads answer one cycle after the read strobe; accesses inside the
//        post-reset window are ignored and read as zero
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

// Word FIFO between the byte packer and the bus-master port
module word_fifo
  import usb_ports_pkg::*;
#(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = FIFO_DEPTH_DFLT
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Depth must be a power of two so pointers wrap naturally
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("word_fifo: DEPTH must be a power of two, at least 2");
  end

  assign in_ready_o = (s.count != (AW + 1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o = mem[s.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and fill level update
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.wp = s.wp + 1'b1;
    end
    if (pop)
    begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.count = s.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[s.wp] <= in_data_i;
    end
  end
endmodule

// Operation
// - Do not fetch a descriptor when too little frame time remains to finish it.
// - Never issue a bus-master cycle with all four byte enables inactive.
// - A wake K state never changes the port's low-speed-attached flag.
// - The wake status bit 8 stays clearable by software after a K-state wake.
// - Ports hold overcurrent, resume detect, enable and connect change, write-one-clear.
// - Command register at index 00h, first port register at index 10h.
module usb_root_ports
  import usb_ports_pkg::*;
#(
  parameter int unsigned FRAME_CYC = FRAME_CYC_DFLT,
  parameter int unsigned PRE_START_OF_FRAME_POINT_CYC = PRE_START_OF_FRAME_POINT_CYC_DFLT,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DFLT
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pci_clock_stop_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic access_ready_o,
  input wire port_line_t [NPORTS-1:0] port_line_i,
  output logic sof_o,
  input wire logic td_req_i,
  input wire logic [15:0] td_need_i,
  output logic td_fetch_o,
  output logic td_defer_o,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire rx_byte_t rx_byte_i,
  input wire logic [1:0] rx_start_lane_i,
  output logic bm_valid_o,
  input wire logic bm_ready_i,
  output bm_word_t bm_word_o
);
  localparam int unsigned FW = $clog2(FRAME_CYC);
  localparam logic [FW-1:0] FRAME_LOAD = FW'(FRAME_CYC - 1);

  // Frame counter is read back in 16 bits
  if (FRAME_CYC > 65536 || PRE_START_OF_FRAME_POINT_CYC >= FRAME_CYC || FRAME_CYC < 2)
  begin : g_bad_frame
    $error("usb_root_ports: frame length out of range");
  end

  typedef struct packed {
    logic [15:0] cmd;
    logic [NPORTS-1:0][15:0] port;
    logic pm_wake;
    logic [31:0] rdata;
    logic [7:0] gate_cnt;
    logic [FW-1:0] frame_cnt;
    logic [15:0] defer_cnt;
    logic [1:0] lane;
    logic first;
    logic full;
    logic [31:0] acc;
    logic [3:0] acc_be_n;
  } state_t;

  state_t s;
  state_t next_s;
  logic ready;
  logic wr_ok;
  logic rd_ok;
  logic running;
  logic fits;
  logic fifo_in_ready;
  logic [NPORTS-1:0][15:0] port_next;
  logic [NPORTS-1:0] res_ev;

  // Register access is held off until the restart window has elapsed
  assign ready = (s.gate_cnt == '0);
  assign wr_ok = reg_wr_i && ready;
  assign rd_ok = reg_rd_i && ready;
  assign access_ready_o = ready;
  assign reg_rdata_o = s.rdata;

  // Frame scheduling decisions
  assign running = s.cmd[CMD_RUN] && !s.cmd[CMD_EGSM];
  assign fits = ({16'h0000, td_need_i} + 32'(PRE_START_OF_FRAME_POINT_CYC)) <= 32'(s.frame_cnt);
  assign sof_o = running && (s.frame_cnt == '0);
  assign td_fetch_o = running && td_req_i && fits;
  assign td_defer_o = running && td_req_i && !fits;

  // Byte packer handshake
  assign rx_ready_o = !s.full;

  // Per-port status and control
  for (genvar p = 0; p < NPORTS; p++)
  begin : g_port
    localparam logic [7:0] PADDR = ADDR_PORT1 + 8'(p * PORT_STRIDE);
    logic [15:0] pn;
    logic [15:0] cur;
    port_line_t ln;

    assign cur = s.port[p];
    assign ln = port_line_i[p];
    // Wake K state seen on a connected port under any suspend
    assign res_ev[p] = ln.k_state && ln.connect && (cur[PS_SUSP] || s.cmd[CMD_EGSM]);

    always_comb
    begin
      pn = cur;
      // Software writes: enable, suspend, write-one-to-clear change bits
      if (wr_ok && reg_addr_i == PADDR)
      begin
        pn[PS_PE] = reg_wdata_i[PS_PE] && cur[PS_CCS];
        pn[PS_SUSP] = reg_wdata_i[PS_SUSP];
        pn = pn & ~(reg_wdata_i[15:0] & PS_W1C_MASK);
      end
      // Hardware sets after the write so a same-cycle event wins
      if (ln.connect && !cur[PS_CCS])
      begin
        pn[PS_LS] = ln.low_speed;
      end
      if (ln.connect != cur[PS_CCS])
      begin
        pn[PS_CSC] = 1'b1;
      end
      pn[PS_CCS] = ln.connect;
      if (pn[PS_PE] && (!ln.connect || ln.overcurrent))
      begin
        pn[PS_PE] = 1'b0;
        pn[PS_PEC] = 1'b1;
      end
      if (ln.overcurrent && !cur[PS_OCA])
      begin
        pn[PS_OCI] = 1'b1;
      end
      pn[PS_OCA] = ln.overcurrent;
      if (res_ev[p])
      begin
        pn[PS_RD] = 1'b1;
      end
      // Host controller reset keeps only the live line status
      if (s.cmd[CMD_HCRESET])
      begin
        pn = pn & PS_HCRESET_KEEP;
      end
    end

    assign port_next[p] = pn;
  end

  // Register file, frame timer and byte packer
  always_comb
  begin
    next_s = s;
    next_s.port = port_next;
    // Restart window: reload while the clocks are stopped, then count down
    if (!pci_clock_stop_n_i)
    begin
      next_s.gate_cnt = 8'(ACCESS_DELAY_CYC);
    end
    else if (!ready)
    begin
      next_s.gate_cnt = s.gate_cnt - 8'h01;
    end
    // Command register; host reset bit clears itself after one cycle
    next_s.cmd[CMD_HCRESET] = 1'b0;
    if (wr_ok && reg_addr_i == ADDR_CMD)
    begin
      next_s.cmd = reg_wdata_i[15:0] & CMD_MASK;
    end
    if (s.cmd[CMD_EGSM] && (|res_ev))
    begin
      next_s.cmd[CMD_FGR] = 1'b1;
    end
    // Wake status: write one clears, a new wake in the same cycle wins
    if (wr_ok && reg_addr_i == ADDR_PM_STS && reg_wdata_i[PM_WAKE])
    begin
      next_s.pm_wake = 1'b0;
    end
    if (|res_ev)
    begin
      next_s.pm_wake = 1'b1;
    end
    // Read data stands in the cycle after the strobe only
    next_s.rdata = '0;
    if (rd_ok)
    begin
      unique case (reg_addr_i)
        ADDR_CMD: next_s.rdata = {16'h0000, s.cmd};
        ADDR_PORT1: next_s.rdata = {16'h0000, s.port[0]};
        ADDR_PORT2: next_s.rdata = {16'h0000, s.port[1]};
        ADDR_PM_STS: next_s.rdata = {23'h0, s.pm_wake, 8'h00};
        ADDR_SCHED: next_s.rdata = {s.defer_cnt, 16'(s.frame_cnt)};
        default: next_s.rdata = '0;
      endcase
    end
    // Frame timer counts down to the start of the next frame
    if (!running)
    begin
      next_s.frame_cnt = FRAME_LOAD;
    end
    else if (s.frame_cnt == '0)
    begin
      next_s.frame_cnt = FRAME_LOAD;
      if (td_req_i && !fits)
      begin
        next_s.defer_cnt = s.defer_cnt + 16'h0001;
      end
    end
    else
    begin
      next_s.frame_cnt = s.frame_cnt - 1'b1;
    end
    // Hand a packed word to the FIFO
    if (s.full && fifo_in_ready)
    begin
      next_s.full = 1'b0;
      next_s.acc = '0;
      next_s.acc_be_n = 4'hf;
    end
    // Pack bytes at their lane; a word is only closed after a byte lands in it
    if (rx_valid_i && !s.full)
    begin
      next_s.lane = s.first ? rx_start_lane_i : s.lane;
      next_s.acc[next_s.lane * 8 +: 8] = rx_byte_i.data;
      next_s.acc_be_n[next_s.lane] = 1'b0;
      next_s.first = rx_byte_i.last;
      if (next_s.lane == 2'h3 || rx_byte_i.last)
      begin
        next_s.full = 1'b1;
        next_s.lane = 2'h0;
      end
      else
      begin
        next_s.lane = next_s.lane + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.cmd <= CMD_RESET;
      s.port <= {NPORTS{PORT_RESET}};
      s.gate_cnt <= 8'(ACCESS_DELAY_CYC);
      s.frame_cnt <= FRAME_LOAD;
      s.first <= 1'b1;
      s.acc_be_n <= 4'hf;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Bus-master word buffer
  word_fifo #(
    .WIDTH($bits(bm_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(s.full),
    .in_ready_o(fifo_in_ready),
    .in_data_i({s.acc, s.acc_be_n}),
    .out_valid_o(bm_valid_o),
    .out_ready_i(bm_ready_i),
    .out_data_o(bm_word_o)
  );
endmodule

// ---- usb_ports_pkg.sv ----
// Purpose: Shared constants and carriers for the root-port, frame and bus-master block
// Assumes: 25 MHz system clock; 32-bit register port, byte address = index * 4
// Notes: Register words are 16 bits wide in the low half of the data bus, except the schedule register, which uses all 32 bits
package usb_ports_pkg;
  localparam int unsigned NPORTS = 2;
  localparam int unsigned CLK_HZ = 25_000_000;
  // Register indices and their byte addresses
  localparam logic [7:0] IDX_CMD = 8'h00;
  localparam logic [7:0] IDX_PORT1 = 8'h10;
  localparam logic [7:0] IDX_PORT2 = 8'h12;
  localparam logic [7:0] IDX_PM_STS = 8'h20;
  localparam logic [7:0] IDX_SCHED = 8'h21;
  localparam logic [7:0] ADDR_CMD = IDX_CMD << 2;
  localparam logic [7:0] ADDR_PORT1 = IDX_PORT1 << 2;
  localparam logic [7:0] ADDR_PORT2 = IDX_PORT2 << 2;
  localparam logic [7:0] ADDR_PM_STS = IDX_PM_STS << 2;
  localparam logic [7:0] ADDR_SCHED = IDX_SCHED << 2;
  localparam logic [7:0] PORT_STRIDE = ADDR_PORT2 - ADDR_PORT1;
  // Command register fields
  localparam int unsigned CMD_RUN = 0;
  localparam int unsigned CMD_HCRESET = 1;
  localparam int unsigned CMD_EGSM = 3;
  localparam int unsigned CMD_FGR = 4;
  localparam logic [15:0] CMD_MASK = 16'h001b;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Port status/control fields
  localparam int unsigned PS_CCS = 0;
  localparam int unsigned PS_CSC = 1;
  localparam int unsigned PS_PE = 2;
  localparam int unsigned PS_PEC = 3;
  localparam int unsigned PS_RD = 6;
  localparam int unsigned PS_LS = 8;
  localparam int unsigned PS_OCA = 10;
  localparam int unsigned PS_OCI = 11;
  localparam int unsigned PS_SUSP = 12;
  localparam logic [15:0] PS_W1C_MASK = 16'h084a;
  localparam logic [15:0] PS_HCRESET_KEEP = 16'h0501;
  localparam logic [15:0] PORT_RESET = 16'h0000;
  // Power management status field
  localparam int unsigned PM_WAKE = 8;
  // Timing
  localparam int unsigned ACCESS_DELAY_NS = 8000;
  localparam int unsigned ACCESS_DELAY_CYC = (ACCESS_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FRAME_NS = 1_000_000;
  localparam int unsigned FRAME_CYC_DFLT = (FRAME_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int unsigned PRE_START_OF_FRAME_POINT_NS = 16000;
  localparam int unsigned PRE_START_OF_FRAME_POINT_CYC_DFLT = (PRE_START_OF_FRAME_POINT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FIFO_DEPTH_DFLT = 16;
  // Carriers
  typedef struct packed {
    logic connect;
    logic low_speed;
    logic k_state;
    logic overcurrent;
  } port_line_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rx_byte_t;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be_n;
  } bm_word_t;
endpackage

// ---- usb_root_ports_checker.sv ----
// Purpose: Port-level assertions for the root-port block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every usb_root_ports instance
`timescale 1ns/100ps
module usb_root_ports_checker
  import usb_ports_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pci_clock_stop_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic access_ready_o,
  input wire logic sof_o,
  input wire logic td_req_i,
  input wire logic td_fetch_o,
  input wire logic td_defer_o,
  input wire logic bm_valid_o,
  input wire logic bm_ready_i,
  input wire bm_word_t bm_word_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Read answers and the post-reset access window
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  blocked_read_a: assert property (reg_rd_i && !access_ready_o |=> reg_rdata_o == 32'h0)
    else $error("read answered inside the access window");
  stop_reload_a: assert property (!pci_clock_stop_n_i |=> !access_ready_o)
    else $error("access open during clock stop");
  window_hold_a: assert property (access_ready_o && pci_clock_stop_n_i |=> access_ready_o)
    else $error("access window closed without cause");
  cmd_readback_a: assert property (reg_wr_i && access_ready_o && reg_addr_i == ADDR_CMD
    && !reg_wdata_i[CMD_HCRESET] && !reg_wdata_i[CMD_EGSM] ##1 !reg_wr_i ##1 reg_rd_i && access_ready_o
    && reg_addr_i == ADDR_CMD |=> reg_rdata_o == ($past(reg_wdata_i, 3) & {16'h0, CMD_MASK}))
    else $error("command register readback wrong");
  // Descriptor gate near the frame boundary
  sof_defer_a: assert property (sof_o && td_req_i |-> td_defer_o && !td_fetch_o)
    else $error("descriptor granted at frame start");
  fetch_grant_a: assert property (td_fetch_o |-> td_req_i && !td_defer_o)
    else $error("grant without request or with refusal");
  sof_gap_a: assert property (sof_o |=> !sof_o [*8])
    else $error("frame starts too close together");
  // Master words
  be_valid_a: assert property (bm_valid_o |-> bm_word_o.be_n != 4'hf)
    else $error("master word with no byte enabled");
  bm_hold_a: assert property (bm_valid_o && !bm_ready_i |=> bm_valid_o && $stable(bm_word_o))
    else $error("master word dropped while stalled");
endmodule

bind usb_root_ports usb_root_ports_checker chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .pci_clock_stop_n_i(pci_clock_stop_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .access_ready_o(access_ready_o),
  .sof_o(sof_o), .td_req_i(td_req_i), .td_fetch_o(td_fetch_o), .td_defer_o(td_defer_o),
  .bm_valid_o(bm_valid_o), .bm_ready_i(bm_ready_i), .bm_word_o(bm_word_o));

// ---- usb_port_devices.sv ----
// Purpose: Two USB devices as seen on the root-port lines
// Assumes: The bench sets attach, speed, wake and overcurrent levels
// Notes: A K state is only driven while a device is attached
`timescale 1ns/100ps
module usb_port_devices
  import usb_ports_pkg::*;
(
  input wire logic [NPORTS-1:0] attach_i,
  input wire logic [NPORTS-1:0] slow_i,
  input wire logic [NPORTS-1:0] wake_i,
  input wire logic [NPORTS-1:0] oc_i,
  output port_line_t [NPORTS-1:0] line_o
);
  // Speed belongs to the device, so a wake K never alters it
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      line_o[p].connect = attach_i[p];
      line_o[p].low_speed = attach_i[p] & slow_i[p];
      line_o[p].k_state = attach_i[p] & wake_i[p];
      line_o[p].overcurrent = oc_i[p];
    end
  end
endmodule

// ---- usb_host_suspend_resume_ports_tb.sv ----
// Purpose: Self-checking bench for the root-port block
// Assumes: Short frame and margin, four-word FIFO
// Notes: Register accesses use one-cycle strobes
`timescale 1ns/100ps
module usb_host_suspend_resume_ports_tb
  import usb_ports_pkg::*;
;
  localparam int unsigned FR = 200;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pci_clock_stop_n_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, td_req_i = 1'b0, rx_valid_i = 1'b0, bm_ready_i = 1'b0;
  logic [15:0] td_need_i = 16'h0;
  rx_byte_t rx_byte_i = '0;
  logic [1:0] rx_start_lane_i = 2'h0, attach = 2'h0, slow = 2'h2, wake = 2'h0, oc = 2'h0;
  logic [31:0] reg_rdata_o;
  logic access_ready_o, sof_o, td_fetch_o, td_defer_o, rx_ready_o, bm_valid_o;
  port_line_t [NPORTS-1:0] port_line_i;
  bm_word_t bm_word_o;
  int errors = 0, n_checks = 0, i;

  // System clock
  always #20 clk_sys_i = ~clk_sys_i;

  usb_root_ports #(.FRAME_CYC(FR), .PRE_START_OF_FRAME_POINT_CYC(20), .FIFO_DEPTH(4)) uut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .pci_clock_stop_n_i(pci_clock_stop_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .access_ready_o(access_ready_o), .port_line_i(port_line_i), .sof_o(sof_o), .td_req_i(td_req_i),
    .td_need_i(td_need_i), .td_fetch_o(td_fetch_o), .td_defer_o(td_defer_o), .rx_valid_i(rx_valid_i),
    .rx_ready_o(rx_ready_o), .rx_byte_i(rx_byte_i), .rx_start_lane_i(rx_start_lane_i),
    .bm_valid_o(bm_valid_o), .bm_ready_i(bm_ready_i), .bm_word_o(bm_word_o));
  usb_port_devices dev (.attach_i(attach), .slow_i(slow), .wake_i(wake), .oc_i(oc), .line_o(port_line_i));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register write and read strobes
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= {16'h0, d};
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(reg_rdata_o & m, e);
    @(posedge clk_sys_i);
  endtask
  task automatic wait_ready();
    for (i = 0; i < 400 && access_ready_o !== 1'b1; i++)
      @(negedge clk_sys_i);
    chk({31'h0, access_ready_o}, 32'h1);
  endtask
  // Byte stream: hold each byte until accepted
  task automatic send(input logic [7:0] d, input logic l, input logic [1:0] ln);
    rx_valid_i <= 1'b1;
    rx_byte_i <= '{data: d, last: l};
    rx_start_lane_i <= ln;
    for (int k = 0; k < 50; k++)
    begin
      @(negedge clk_sys_i);
      if (rx_ready_o === 1'b1)
        break;
    end
    @(posedge clk_sys_i);
  endtask
  // Master side: wait for a word while ready is held high
  task automatic take(input logic [31:0] d, input logic [31:0] dm, input logic [3:0] be);
    @(negedge clk_sys_i);
    for (int k = 0; k < 50 && bm_valid_o !== 1'b1; k++)
      @(negedge clk_sys_i);
    chk(bm_word_o.data & dm, d);
    chk({bm_valid_o, 27'h0, bm_word_o.be_n}, {1'b1, 27'h0, be});
    @(posedge clk_sys_i);
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #(40 * 20000);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    attach <= 2'h3;
    wr(ADDR_CMD, 16'h0001);
    rd(ADDR_PORT1, 32'h0);
    wait_ready();
    rd(ADDR_CMD, 32'h0);
    wr(ADDR_CMD, 16'h0010);
    rd(ADDR_CMD, 32'h0010);
    wr(ADDR_CMD, 16'h0000);
    rd(ADDR_PORT1, 32'h0003);
    rd(ADDR_PORT2, 32'h0103);
    rd(8'hfc, 32'h0);
    wr(ADDR_PORT1, 16'h0002);
    wr(ADDR_PORT2, 16'h0002);
    rd(ADDR_PORT1, 32'h0001);
    oc <= 2'h2;
    repeat (3) @(posedge clk_sys_i);
    rd(ADDR_PORT2, 32'h0d01, 32'hfffffff7);
    oc <= 2'h0;
    wr(ADDR_PORT2, 16'h0808);
    rd(ADDR_PORT2, 32'h0101);
    // Suspend, wake by a full-speed K, then the resume clean-up order
    wr(ADDR_PORT1, 16'h1000);
    wr(ADDR_PORT2, 16'h1000);
    wr(ADDR_CMD, 16'h0008);
    wake <= 2'h1;
    repeat (4) @(posedge clk_sys_i);
    wake <= 2'h0;
    rd(ADDR_PORT1, 32'h1041);
    rd(ADDR_CMD, 32'h0018);
    rd(ADDR_PM_STS, 32'h0100);
    repeat (50) @(posedge clk_sys_i);
    wr(ADDR_CMD, 16'h0008);
    wr(ADDR_CMD, 16'h0000);
    wr(ADDR_PORT1, 16'h1040);
    wr(ADDR_PORT1, 16'h0000);
    wr(ADDR_PORT2, 16'h0000);
    wr(ADDR_PM_STS, 16'h0100);
    rd(ADDR_PM_STS, 32'h0);
    rd(ADDR_PORT1, 32'h0001);
    // Global suspend set first this time; speed and wake status must still behave
    wr(ADDR_CMD, 16'h0008);
    wake <= 2'h1;
    repeat (4) @(posedge clk_sys_i);
    wake <= 2'h0;
    rd(ADDR_PORT1, 32'h0041);
    wr(ADDR_CMD, 16'h0000);
    wr(ADDR_PORT1, 16'h0040);
    wr(ADDR_PM_STS, 16'h0100);
    rd(ADDR_PM_STS, 32'h0);
    // Clock stop reopens the access window
    @(posedge clk_sys_i);
    pci_clock_stop_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    pci_clock_stop_n_i <= 1'b1;
    rd(ADDR_PORT1, 32'h0);
    wait_ready();
    rd(ADDR_PORT1, 32'h0001);
    // Descriptor gate: margin 20, counter reloads to FR-1 after a frame start
    wr(ADDR_CMD, 16'h0001);
    for (i = 0; i < 400 && sof_o !== 1'b1; i++)
      @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    td_req_i <= 1'b1;
    td_need_i <= 16'd10;
    @(negedge clk_sys_i);
    chk({30'h0, td_fetch_o, td_defer_o}, 32'h2);
    @(posedge clk_sys_i);
    td_need_i <= 16'd190;
    @(negedge clk_sys_i);
    chk({30'h0, td_fetch_o, td_defer_o}, 32'h1);
    @(posedge clk_sys_i);
    td_need_i <= 16'd177;
    @(negedge clk_sys_i);
    chk({30'h0, td_fetch_o, td_defer_o}, 32'h2);
    @(posedge clk_sys_i);
    td_need_i <= 16'd10;
    // A request still pending at the frame start is refused and counted
    for (i = 0; i < 400 && sof_o !== 1'b1; i++)
      @(negedge clk_sys_i);
    chk({29'h0, sof_o, td_fetch_o, td_defer_o}, 32'h5);
    @(posedge clk_sys_i);
    td_req_i <= 1'b0;
    rd(ADDR_SCHED, 32'h00010000, 32'hffff0000);
    // Fill the FIFO with the master stalled, then drain it
    for (i = 0; i < 20; i++)
      send(i[7:0], i == 19, 2'h0);
    rx_valid_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({31'h0, rx_ready_o}, 32'h0);
    @(posedge clk_sys_i);
    bm_ready_i <= 1'b1;
    for (i = 0; i < 5; i++)
      take({8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)}, 32'hffffffff, 4'h0);
    // Unaligned buffers: lanes 2..3, then lanes 1..3
    send(8'ha5, 1'b0, 2'h2);
    send(8'h5a, 1'b1, 2'h2);
    rx_valid_i <= 1'b0;
    take(32'h5aa50000, 32'hffff0000, 4'h3);
    send(8'h11, 1'b0, 2'h1);
    send(8'h22, 1'b0, 2'h1);
    send(8'h33, 1'b1, 2'h1);
    rx_valid_i <= 1'b0;
    take(32'h33221100, 32'hffffff00, 4'h1);
    end_of_test();
  end
endmodule
